// >>> common/ccr_params.svh
// Purpose: offsets, field positions, reset values, timing counts
// Assumes: byte registers on a 32-bit Avalon-MM word grid
// Notes:   included only by the ccr_core module of the clock controller
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH

// ----------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define CCR_IDX_SYSDIV   4'h0
`define CCR_IDX_RTC_SOURCE_FIELD   4'h1
`define CCR_IDX_ICK      4'h2
`define CCR_IDX_GATE1    4'h3
`define CCR_IDX_GATE2    4'h4
`define CCR_IDX_IRQ      4'h5
`define CCR_IDX_STATUS   4'h6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CCR_RST_SYSDIV   8'h03
`define CCR_RST_RTC_SOURCE_FIELD   8'h00
`define CCR_RST_ICK      8'h11
`define CCR_RST_GATE1    8'h00
`define CCR_RST_GATE2    8'h80
`define CCR_GATE2_MASK   8'hbf

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CCR_ICK_BEEP     6
`define CCR_ICK_FAST_HALT_WAKEUP     5
`define CCR_ICK_SLOW_HALT_REGULATOR_OFF   4
`define CCR_ICK_SRDY     3
`define CCR_ICK_SEN      2
`define CCR_ICK_FRDY     1
`define CCR_ICK_FEN      0
`define CCR_IRQ_SWF      0
`define CCR_IRQ_SWEN     1
`define CCR_IRQ_SECF     2
`define CCR_IRQ_SECEN    3

// ----------------------------------------------------------------
// timing: rtc switch handshake time
// ----------------------------------------------------------------
`define CCR_CLK_MHZ      20
`define CCR_RTC_SW_NS    400
`define CCR_RTC_SW_CYC   ((`CCR_RTC_SW_NS * `CCR_CLK_MHZ + 999) / 1000)

`endif

// >>> common/ccr_pkg.sv
// Purpose: shared types of the clock controller
// Assumes: nothing
// Notes:   constants live in ccr_params.svh
package ccr_pkg;
	typedef enum logic [1:0] {
		CCR_RTC_IDLE = 2'b00,
		CCR_RTC_BUSY = 2'b01
	} ccr_rtc_e;
	typedef logic [7:0] ccr_byte_t;
endpackage

// >>> common/ccr_osc_if.sv
// Purpose: oscillator demand and status between core and arbiter
// Assumes: single clock
// Notes:   carries forced-on terms and software enables
`timescale 1ns/1ps
interface ccr_osc_if;
	logic sw_slow_en;
	logic sw_fast_en;
	logic force_slow;
	logic force_fast;
	logic keep_slow;
	logic keep_fast;
	logic slow_en;
	logic fast_en;
	modport core (output sw_slow_en, output sw_fast_en,
		output force_slow, output force_fast, output keep_slow,
		output keep_fast, input slow_en, input fast_en);
	modport arb (input sw_slow_en, input sw_fast_en,
		input force_slow, input force_fast, input keep_slow,
		input keep_fast, output slow_en, output fast_en);
endinterface

// >>> core/ccr_osc_arb.sv
// Purpose: oscillator enable arbitration
// Assumes: software values come from writes to the enable bits
// Notes:   hardware demand wins over a software clear
`timescale 1ns/1ps
module ccr_osc_arb
(
	ccr_osc_if.arb	osc
);
	import ccr_pkg::*;

	// ----------------------------------------------------------------
	// effective enables
	// ----------------------------------------------------------------
	assign osc.slow_en = osc.sw_slow_en | osc.force_slow
		| osc.keep_slow;
	assign osc.fast_en = osc.sw_fast_en | osc.force_fast
		| osc.keep_fast;
endmodule // ccr_osc_arb

// >>> core/ccr_rtc_sync.sv
// Purpose: two-flop synchroniser for oscillator ready levels
// Assumes: ready levels come from free-running oscillators
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module ccr_rtc_sync
(
	input  wire logic	i_clk,
	input  wire logic	i_srst,
	input  wire logic [1:0]	i_async,
	output logic [1:0]	o_sync
);
	import ccr_pkg::*;
	logic [1:0] meta_q;
	logic [1:0] sync_q;

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			meta_q <= 2'h0;
			sync_q <= 2'h0;
		end
		else
		begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end
	assign o_sync = sync_q;
endmodule // ccr_rtc_sync

// >>> core/ccr_core.sv
// Purpose: clock controller control registers and gating
// Assumes: Avalon-MM slave, 20 MHz i_clk, i_por_srst is power-on
// Notes:   one wait state on every access
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "ccr_params.svh"
module ccr_core
(
	input  wire logic		i_clk,
	input  wire logic		i_srst,
	input  wire logic		i_por_srst,
	input  wire logic [3:0]		i_avs_address,
	input  wire logic		i_avs_read,
	input  wire logic		i_avs_write,
	input  wire logic [31:0]	i_avs_writedata,
	input  wire logic [3:0]		i_avs_byteenable,
	output logic [31:0]		o_avs_readdata,
	output logic			o_avs_waitrequest,
	input  wire logic		i_switch_event,
	input  wire logic		i_security_event,
	input  wire logic		i_wait_mode,
	input  wire logic		i_halt_mode,
	input  wire logic		i_halt_exit,
	input  wire logic [3:0]		i_main_src,
	input  wire logic [3:0]		i_switch_target,
	input  wire logic [3:0]		i_clkout_src,
	input  wire logic [1:0]		i_beep_src,
	input  wire logic		i_slow_measure,
	input  wire logic		i_safe_osc,
	input  wire logic		i_slow_osc_ready,
	input  wire logic		i_fast_osc_ready,
	output logic			o_irq,
	output logic			o_wake,
	output logic [2:0]		o_sys_prescale,
	output logic [2:0]		o_rtc_divide,
	output logic [3:0]		o_rtc_source,
	output logic			o_rtc_switch_pending,
	output logic			o_beep_clk_en,
	output logic			o_wake_fast_div8,
	output logic			o_regulator_off,
	output logic			o_slow_osc_en,
	output logic			o_fast_osc_en,
	output logic [7:0]		o_gate_bank_one,
	output logic [7:0]		o_gate_bank_two
);
	import ccr_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic onehot0(input logic [3:0] v);
		onehot0 = (v & (v - 4'h1)) == 4'h0;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	ccr_byte_t	sysdiv_q;
	ccr_byte_t	ick_q;
	ccr_byte_t	gate1_q;
	ccr_byte_t	gate2_q;
	logic [2:0]	rtc_div_q;
	logic [3:0]	rtc_src_q;
	ccr_rtc_e	rtc_st_q;
	logic [4:0]	rtc_cnt_q;
	logic [3:0]	irq_q;
	logic		ack_q;
	logic [31:0]	rdata_q;
	logic [1:0]	ready_s;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire req      = i_avs_read | i_avs_write;
	wire wr_fire  = i_avs_write & ack_q & i_avs_byteenable[0];
	wire wr_sys   = wr_fire & (i_avs_address == `CCR_IDX_SYSDIV);
	wire wr_rtc   = wr_fire & (i_avs_address == `CCR_IDX_RTC_SOURCE_FIELD);
	wire wr_ick   = wr_fire & (i_avs_address == `CCR_IDX_ICK);
	wire wr_g1    = wr_fire & (i_avs_address == `CCR_IDX_GATE1);
	wire wr_g2    = wr_fire & (i_avs_address == `CCR_IDX_GATE2);
	wire wr_irq   = wr_fire & (i_avs_address == `CCR_IDX_IRQ);
	wire [7:0] wd = i_avs_writedata[7:0];

	// one wait state: waitrequest drops in the second cycle
	assign o_avs_waitrequest = req & ~ack_q;

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			ack_q <= 1'b0;
		else
			ack_q <= req & ~ack_q;
	end

	// ----------------------------------------------------------------
	// rtc register, power-on reset only
	// ----------------------------------------------------------------
	wire rtc_busy  = (rtc_st_q == CCR_RTC_BUSY);
	wire [2:0] new_div = wd[7:5];
	wire [3:0] new_src = wd[4:1];
	wire rtc_valid = onehot0(new_src);
	wire rtc_take  = wr_rtc & ~rtc_busy & rtc_valid;
	wire rtc_chg   = rtc_take & ((new_div != rtc_div_q)
		| (new_src != rtc_src_q));
	wire [4:0] rtc_cyc = 5'(`CCR_RTC_SW_CYC);
	wire [7:0] rtc_rst = `CCR_RST_RTC_SOURCE_FIELD;

	always_ff @(posedge i_clk)
	begin
		if (i_por_srst)
		begin
			rtc_div_q <= rtc_rst[7:5];
			rtc_src_q <= rtc_rst[4:1];
			rtc_st_q  <= CCR_RTC_IDLE;
			rtc_cnt_q <= 5'h0;
		end
		else
		begin
			if (rtc_take)
			begin
				rtc_div_q <= new_div;
				rtc_src_q <= new_src;
			end
			case (rtc_st_q)
				CCR_RTC_IDLE:
					if (rtc_chg)
					begin
						rtc_st_q  <= CCR_RTC_BUSY;
						rtc_cnt_q <= rtc_cyc;
					end
				CCR_RTC_BUSY:
					if (rtc_cnt_q == 5'h1)
						rtc_st_q <= CCR_RTC_IDLE;
					else
						rtc_cnt_q <= rtc_cnt_q - 5'h1;
				default:
					rtc_st_q <= CCR_RTC_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// system reset registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			sysdiv_q <= `CCR_RST_SYSDIV;
			ick_q    <= `CCR_RST_ICK;
			gate1_q  <= `CCR_RST_GATE1;
			gate2_q  <= `CCR_RST_GATE2;
		end
		else
		begin
			if (wr_sys)
				sysdiv_q <= {5'h0, wd[2:0]};
			if (wr_ick)
				ick_q <= wd & 8'h75;
			if (wr_g1)
				gate1_q <= wd;
			if (wr_g2)
				gate2_q <= wd & `CCR_GATE2_MASK;
		end
	end

	// ----------------------------------------------------------------
	// interrupt flags: set wins over clear
	// ----------------------------------------------------------------
	wire clr_sw  = wr_irq & ~wd[`CCR_IRQ_SWF];
	wire clr_sec = wr_irq & ~wd[`CCR_IRQ_SECF];

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			irq_q <= 4'h0;
		else
		begin
			if (wr_irq)
			begin
				irq_q[`CCR_IRQ_SWEN]  <= wd[`CCR_IRQ_SWEN];
				irq_q[`CCR_IRQ_SECEN] <= wd[`CCR_IRQ_SECEN];
			end
			irq_q[`CCR_IRQ_SWF] <= i_switch_event
				| (irq_q[`CCR_IRQ_SWF] & ~clr_sw);
			irq_q[`CCR_IRQ_SECF] <= i_security_event
				| (irq_q[`CCR_IRQ_SECF] & ~clr_sec);
		end
	end

	wire irq_any = (irq_q[`CCR_IRQ_SWF] & irq_q[`CCR_IRQ_SWEN])
		| (irq_q[`CCR_IRQ_SECF] & irq_q[`CCR_IRQ_SECEN]);
	assign o_irq  = irq_any;
	// halt exit is the job of other wakeup sources
	assign o_wake = irq_any & i_wait_mode & ~i_halt_mode;

	// ----------------------------------------------------------------
	// oscillator control
	// ----------------------------------------------------------------
	ccr_rtc_sync u_sync
	(
		.i_clk   (i_clk),
		.i_srst  (i_srst),
		.i_async ({i_slow_osc_ready, i_fast_osc_ready}),
		.o_sync  (ready_s)
	);

	ccr_osc_if osc ();
	wire beep_slow = i_beep_src[1];
	assign osc.sw_slow_en = ick_q[`CCR_ICK_SEN];
	assign osc.sw_fast_en = ick_q[`CCR_ICK_FEN];
	assign osc.force_slow = i_switch_target[1] | i_slow_measure
		| beep_slow;
	assign osc.keep_slow  = i_main_src[1] | i_clkout_src[1]
		| rtc_src_q[1] | (beep_slow & ick_q[`CCR_ICK_BEEP]);
	assign osc.force_fast = i_safe_osc | i_switch_target[0]
		| (i_halt_exit & ick_q[`CCR_ICK_FAST_HALT_WAKEUP]);
	assign osc.keep_fast  = i_main_src[0] | i_clkout_src[0]
		| rtc_src_q[0];

	ccr_osc_arb u_arb
	(
		.osc (osc.arb)
	);

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	wire [7:0] ick_rd = {1'b0, ick_q[6:4], ready_s[1], osc.slow_en,
		ready_s[0], osc.fast_en};
	wire [7:0] rtc_rd = {rtc_div_q, rtc_src_q, rtc_busy};
	wire [7:0] stat_rd = {6'h0, ready_s};
	logic [7:0] rsel;
	always_comb
	begin
		case (i_avs_address)
			`CCR_IDX_SYSDIV: rsel = sysdiv_q;
			`CCR_IDX_RTC_SOURCE_FIELD: rsel = rtc_rd;
			`CCR_IDX_ICK:    rsel = ick_rd;
			`CCR_IDX_GATE1:  rsel = gate1_q;
			`CCR_IDX_GATE2:  rsel = gate2_q;
			`CCR_IDX_IRQ:    rsel = {4'h0, irq_q};
			`CCR_IDX_STATUS: rsel = stat_rd;
			default:         rsel = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			rdata_q <= 32'h0000_0000;
		else if (i_avs_read & ~ack_q)
			rdata_q <= {24'h00_0000, rsel};
	end
	assign o_avs_readdata = rdata_q;

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_sys_prescale       = sysdiv_q[2:0];
	assign o_rtc_divide         = rtc_div_q;
	assign o_rtc_source         = rtc_src_q;
	assign o_rtc_switch_pending = rtc_busy;
	assign o_beep_clk_en = gate1_q[6] & (~i_halt_mode
		| ick_q[`CCR_ICK_BEEP]);
	assign o_wake_fast_div8 = ick_q[`CCR_ICK_FAST_HALT_WAKEUP];
	assign o_regulator_off = ick_q[`CCR_ICK_SLOW_HALT_REGULATOR_OFF]
		& i_halt_mode;
	assign o_slow_osc_en   = osc.slow_en;
	assign o_fast_osc_en   = osc.fast_en;
	assign o_gate_bank_one = gate1_q;
	assign o_gate_bank_two = gate2_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_irq_mask;
		@(posedge i_clk) disable iff (i_srst)
		(~irq_q[`CCR_IRQ_SWEN] & ~irq_q[`CCR_IRQ_SECEN]) |-> ~o_irq;
	endproperty
	a_irq_mask: assert property (p_irq_mask)
		else $error("irq with both enables off");

	property p_no_halt_wake;
		@(posedge i_clk) disable iff (i_srst)
		i_halt_mode |-> ~o_wake;
	endproperty
	a_no_halt_wake: assert property (p_no_halt_wake)
		else $error("wake asserted in halt");

	property p_rtc_frozen;
		@(posedge i_clk) disable iff (i_por_srst)
		rtc_busy |=> $stable(rtc_src_q) && $stable(rtc_div_q);
	endproperty
	a_rtc_frozen: assert property (p_rtc_frozen)
		else $error("rtc source changed while pending");

	property p_rtc_onehot;
		@(posedge i_clk) disable iff (i_por_srst)
		onehot0(rtc_src_q);
	endproperty
	a_rtc_onehot: assert property (p_rtc_onehot)
		else $error("rtc source not one-hot");

	property p_rtc_busy_len;
		@(posedge i_clk) disable iff (i_por_srst)
		rtc_chg && !rtc_busy |=> rtc_busy [*8] ##1 !rtc_busy;
	endproperty
	a_rtc_busy_len: assert property (p_rtc_busy_len)
		else $error("rtc pending length wrong");

	property p_slow_keep;
		@(posedge i_clk) disable iff (i_srst)
		rtc_src_q[1] |-> o_slow_osc_en;
	endproperty
	a_slow_keep: assert property (p_slow_keep)
		else $error("slow osc off while rtc source");

	property p_fast_safe;
		@(posedge i_clk) disable iff (i_srst)
		i_safe_osc |-> o_fast_osc_en;
	endproperty
	a_fast_safe: assert property (p_fast_safe)
		else $error("fast osc off in safe mode");

	property p_gate2_rsv;
		@(posedge i_clk) disable iff (i_srst)
		!gate2_q[6];
	endproperty
	a_gate2_rsv: assert property (p_gate2_rsv)
		else $error("reserved gate bit set");
endmodule // ccr_core

// >>> tb/ccr_osc_model.sv
// Purpose: oscillators on the far side of the enables
// Assumes: ready rises a few cycles after enable, drops at the next clock edge
// Notes:   start-up time is a plain parameter, not a real figure
`timescale 1ns/1ps
module ccr_osc_model
#(
	parameter int START_CYC = 4
)
(
	input  wire logic	i_clk,
	input  wire logic	i_slow_en,
	input  wire logic	i_fast_en,
	output logic		o_slow_ready,
	output logic		o_fast_ready
);
	int slow_cnt = 0;
	int fast_cnt = 0;
	// ready drops at the first edge after enable falls, so a stale flag lasts at most one cycle
	always @(posedge i_clk)
	begin
		if (!i_slow_en)
			slow_cnt <= 0;
		else if (slow_cnt < START_CYC)
			slow_cnt <= slow_cnt + 1;
		if (!i_fast_en)
			fast_cnt <= 0;
		else if (fast_cnt < START_CYC)
			fast_cnt <= fast_cnt + 1;
	end
	assign o_slow_ready = (slow_cnt == START_CYC);
	assign o_fast_ready = (fast_cnt == START_CYC);
endmodule // ccr_osc_model

// >>> tb/tb_top.sv
// Purpose: self-checking bench of the clock controller registers
// Assumes: one wait state per access, byte regs at index*4
// Notes:   reset values first, then table rows, rtc, reset, irq, halt, osc cases
`timescale 1ns/1ps
module tb_top;
	import ccr_pkg::*;
	typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] e;} ccr_row_s;
	logic i_clk = 0, i_srst = 1, i_por_srst = 1;
	logic [3:0] adr = 0, be = 4'hf, msrc = 0, tgt = 0, cko = 0;
	logic rd = 0, wr = 0, swe = 0, sece = 0, wmode = 0, hmode = 0;
	logic hexit = 0, meas = 0, safe = 0, srdy, frdy;
	logic [1:0] bsrc = 0;
	logic [31:0] wd = 0, rdata;
	logic wreq, irq, wake, pend, beep, fdiv8, regoff, sen, fen;
	logic [2:0] pre, rdiv;
	logic [3:0] rsrc;
	logic [7:0] g1, g2, q;
	int fail_count = 0, n_checks = 0;
	ccr_row_s rows [6] = '{'{4'h0, 8'hff, 8'h07}, '{4'h0, 8'h05, 8'h05},
		'{4'h3, 8'ha5, 8'ha5}, '{4'h4, 8'hff, 8'hbf},
		'{4'h4, 8'h00, 8'h00}, '{4'h7, 8'hff, 8'h00}};
	always #25 i_clk = ~i_clk;
	ccr_core u_ccr_core (.i_clk(i_clk), .i_srst(i_srst),
		.i_por_srst(i_por_srst), .i_avs_address(adr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
		.i_switch_event(swe), .i_security_event(sece),
		.i_wait_mode(wmode), .i_halt_mode(hmode), .i_halt_exit(hexit),
		.i_main_src(msrc), .i_switch_target(tgt), .i_clkout_src(cko),
		.i_beep_src(bsrc), .i_slow_measure(meas), .i_safe_osc(safe),
		.i_slow_osc_ready(srdy), .i_fast_osc_ready(frdy), .o_irq(irq),
		.o_wake(wake), .o_sys_prescale(pre), .o_rtc_divide(rdiv),
		.o_rtc_source(rsrc), .o_rtc_switch_pending(pend),
		.o_beep_clk_en(beep), .o_wake_fast_div8(fdiv8),
		.o_regulator_off(regoff), .o_slow_osc_en(sen),
		.o_fast_osc_en(fen), .o_gate_bank_one(g1), .o_gate_bank_two(g2));
	ccr_osc_model u_ccr_osc_model (.i_clk(i_clk), .i_slow_en(sen),
		.i_fast_en(fen), .o_slow_ready(srdy), .o_fast_ready(frdy));
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [7:0] d);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= {24'h0, d};
		// no local limit: only the watchdog ends a hung access
		do
			@(posedge i_clk);
		while (wreq !== 1'b0);
		q = rdata[7:0];
		rd <= 0;
		wr <= 0;
		@(posedge i_clk);
	endtask
	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(q, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		tick(3000);
		fail_count++;
		give_verdict;
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		tick(4);
		i_srst <= 0;
		i_por_srst <= 0;
		rchk(4'h0, 8'h03);
		rchk(4'h1, 8'h00);
		bus(1'b0, 4'h2, 8'h00);
		chk(q & 8'hf5, 8'h11);
		rchk(4'h3, 8'h00);
		rchk(4'h4, 8'h80);
		tick(8);
		rchk(4'h6, 8'h01);
		rchk(4'h2, 8'h13);
		foreach (rows[i])
		begin
			bus(1'b1, rows[i].a, rows[i].d);
			rchk(rows[i].a, rows[i].e);
		end
		chk(pre, 3'd5);
		chk(g1, 8'ha5);
		chk(g2, 8'h00);
		// rtc: invalid source dropped, valid change freezes fields
		bus(1'b1, 4'h1, 8'h06);
		rchk(4'h1, 8'h00);
		bus(1'b1, 4'h1, 8'h24);
		chk(pend, 1'b1);
		bus(1'b1, 4'h1, 8'h42);
		tick(12);
		chk(pend, 1'b0);
		rchk(4'h1, 8'h24);
		chk(rsrc, 4'b0010);
		chk(rdiv, 3'd1);
		// system reset keeps the rtc register
		i_srst <= 1;
		tick(1);
		i_srst <= 0;
		tick(3);
		rchk(4'h1, 8'h24);
		rchk(4'h4, 8'h80);
		rchk(4'h0, 8'h03);
		// interrupts: security masked, switch enabled
		bus(1'b1, 4'h5, 8'h02);
		sece <= 1;
		tick(1);
		sece <= 0;
		tick(2);
		chk(irq, 1'b0);
		swe <= 1;
		wmode <= 1;
		tick(1);
		swe <= 0;
		tick(2);
		chk(irq, 1'b1);
		chk(wake, 1'b1);
		hmode <= 1;
		tick(1);
		chk(wake, 1'b0);
		rchk(4'h5, 8'h07);
		bus(1'b1, 4'h5, 8'h02);
		rchk(4'h5, 8'h02);
		chk(irq, 1'b0);
		// halt options with beeper gate open
		wmode <= 0;
		bus(1'b1, 4'h3, 8'h40);
		bus(1'b1, 4'h2, 8'h71);
		chk(beep, 1'b1);
		chk(regoff, 1'b1);
		chk(fdiv8, 1'b1);
		bus(1'b1, 4'h2, 8'h01);
		chk(beep, 1'b0);
		chk(regoff, 1'b0);
		chk(fdiv8, 1'b0);
		hmode <= 0;
		tick(1);
		chk(beep, 1'b1);
		// oscillator clears refused while in use
		msrc <= 4'b0001;
		bus(1'b1, 4'h2, 8'h00);
		chk(sen, 1'b1);
		chk(fen, 1'b1);
		msrc <= 4'b0000;
		tick(1);
		chk(fen, 1'b0);
		safe <= 1;
		tick(1);
		chk(fen, 1'b1);
		safe <= 0;
		// power-on reset clears the rtc register
		i_srst <= 1;
		i_por_srst <= 1;
		tick(1);
		i_srst <= 0;
		i_por_srst <= 0;
		tick(3);
		rchk(4'h1, 8'h00);
		// hardware demands hold the oscillators on
		bus(1'b1, 4'h2, 8'h20);
		chk(sen, 1'b0);
		chk(fen, 1'b0);
		meas <= 1;
		tick(1);
		chk(sen, 1'b1);
		meas <= 0;
		bsrc <= 2'b10;
		tick(1);
		chk(sen, 1'b1);
		bsrc <= 2'b00;
		tgt <= 4'b0010;
		tick(1);
		chk(sen, 1'b1);
		tgt <= 4'b0001;
		tick(1);
		chk(fen, 1'b1);
		tgt <= 4'b0000;
		hexit <= 1;
		tick(1);
		chk(fen, 1'b1);
		hexit <= 0;
		cko <= 4'b0010;
		tick(1);
		chk(sen, 1'b1);
		cko <= 4'b0001;
		tick(1);
		chk(fen, 1'b1);
		cko <= 4'b0000;
		tick(1);
		chk(sen, 1'b0);
		chk(fen, 1'b0);
		give_verdict;
	end
endmodule // tb_top
